// [core/agl_config_regs.sv]
// Summary of operation
// - The byte at 0x04 is reserved, resets to 00000101 and keeps that value whatever is written.
// - In loudspeaker plus low-gain mode the gain codes 00000 to 10001 are legal and the default is 00000.
// - In loudspeaker mode without low gain only gain codes 01000 to 10001 are legal and the default is 10000.
// - In receiver mode gain codes 00000 to 00110 are legal and the default is 00000.
// - A reserved gain or ceiling code turns into that field's default for the active mode.
// - In loudspeaker plus low-gain mode every third limiter ceiling code is legal, 1111 turns the limiter off, default 0000.
// - In loudspeaker mode without low gain third limiter ceiling codes 0100 to 1111 are legal and the default is 0111.
// - In receiver mode the only legal third limiter ceiling code is 1111, which is also the default.
// - Bits 7:5 of 0x07 hold the release rate with reset code 010.
// - Bits 4:2 of 0x07 hold the attack rate with reset code 011.
// - Bits 1:0 of 0x07 hold the first-attack rate with reset code 10.
// - Bit 2 of 0x02 selects loudspeaker mode and bit 1 low gain, and they pick the encodings.
// - Writing 0xaa to offset 0x00 puts every configuration register back to its default.
`default_nettype none

module agl_config_regs
    import agl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // two-wire bus pins and address straps
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addrPin2,
    input wire logic addrPin1,
    // amplifier configuration
    output logic chargePumpDouble,
    output logic loudspeakerModeSelect,
    output logic lowAmplificationSelect,
    output logic classAbSelect,
    output logic [4:0] gainCode,
    output logic [3:0] limiter3CeilingField,
    output logic [2:0] limiter3ReleaseRate,
    output logic [2:0] limiter3AttackRate,
    output logic [1:0] limiter3InitialAttackRate,
    output logic [3:0] limiter2CeilingField
);

    typedef struct packed {
        logic [3:0] mode;
        logic [7:0] pumpParameterByte;
        logic [4:0] gain;
        logic [3:0] ceil3;
        logic [7:0] timing;
        logic [3:0] ceil2;
    } agl_cfg_s;

    localparam agl_cfg_s CFG_RESET = '{mode: MODE_RESET, pumpParameterByte: PUMP_RESET,
        gain: GAIN_DEF_NORMAL, ceil3: CEIL3_DEF_NORMAL, timing: TIMING_RESET, ceil2: CEIL2_DEF_SPK};

    function automatic logic gainOk(input logic [4:0] g, input logic spk, input logic lg);
        if (!spk) begin
            return g <= GAIN_MAX_RCV;
        end else if (lg) begin
            return g <= GAIN_MAX;
        end
        return (g >= GAIN_MIN_NORMAL) && (g <= GAIN_MAX);
    endfunction : gainOk

    function automatic logic [4:0] gainDef(input logic spk, input logic lg);
        if (!spk) begin
            return GAIN_DEF_RCV;
        end
        return lg ? GAIN_DEF_LOWG : GAIN_DEF_NORMAL;
    endfunction : gainDef

    function automatic logic ceil3Ok(input logic [3:0] c, input logic spk, input logic lg);
        if (!spk) begin
            return c == CEIL3_OFF;
        end else if (lg) begin
            return 1'b1;
        end
        return c >= CEIL3_MIN_NORMAL;
    endfunction : ceil3Ok

    function automatic logic [3:0] ceil3Def(input logic spk, input logic lg);
        if (!spk) begin
            return CEIL3_DEF_RCV;
        end
        return lg ? CEIL3_DEF_LOWG : CEIL3_DEF_NORMAL;
    endfunction : ceil3Def

    function automatic logic ceil2Ok(input logic [3:0] c, input logic spk);
        return spk ? (c <= CEIL2_MAX_SPK) : (c == CEIL2_OFF_RCV);
    endfunction : ceil2Ok

    agl_cfg_s cfg_ff;
    agl_cfg_s nxt_cfg;
    logic wrStrobe;
    logic [7:0] wrAddr;
    logic [7:0] wrData;
    logic [7:0] regPtr;
    logic [7:0] rdData;
    logic spk;
    logic lg;

    agl_i2c_target agl_i2c_target_inst (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .addrPin2(addrPin2),
        .addrPin1(addrPin1),
        .wrStrobe(wrStrobe),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .regPtr(regPtr),
        .rdData(rdData)
    );

    // readback; unmapped offsets and unused upper bits read zero
    always_comb begin
        case (regPtr)
            ADDR_ID: rdData = ID_VALUE;
            ADDR_MODE: rdData = {4'h0, cfg_ff.mode};
            ADDR_PUMP: rdData = cfg_ff.pumpParameterByte;
            ADDR_GAIN: rdData = {3'h0, cfg_ff.gain};
            ADDR_CEIL3: rdData = {4'h0, cfg_ff.ceil3};
            ADDR_TIMING: rdData = cfg_ff.timing;
            ADDR_CEIL2: rdData = {4'h0, cfg_ff.ceil2};
            default: rdData = 8'h00;
        endcase
    end

    always_comb begin
        nxt_cfg = cfg_ff;
        if (wrStrobe) begin
            case (wrAddr)
                ADDR_ID: begin
                    if (wrData == ID_RESET_KEY) begin
                        nxt_cfg = CFG_RESET;
                    end
                end
                ADDR_MODE: nxt_cfg.mode = wrData[3:0];
                ADDR_GAIN: nxt_cfg.gain = wrData[4:0];
                ADDR_CEIL3: nxt_cfg.ceil3 = wrData[3:0];
                ADDR_TIMING: nxt_cfg.timing = wrData;
                ADDR_CEIL2: nxt_cfg.ceil2 = wrData[3:0];
                default: begin
                end
            endcase
        end
        spk = nxt_cfg.mode[MODE_SPK_BIT];
        lg = nxt_cfg.mode[MODE_LG_BIT];
        // checked against the new mode, so a mode write also repairs fields left illegal by it
        // reserved code fallback
        if (!gainOk(nxt_cfg.gain, spk, lg)) begin
            nxt_cfg.gain = gainDef(spk, lg);
        end
        if (!ceil3Ok(nxt_cfg.ceil3, spk, lg)) begin
            nxt_cfg.ceil3 = ceil3Def(spk, lg);
        end
        if (!ceil2Ok(nxt_cfg.ceil2, spk)) begin
            nxt_cfg.ceil2 = spk ? CEIL2_DEF_SPK : CEIL2_OFF_RCV;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_ff <= CFG_RESET;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    assign chargePumpDouble = cfg_ff.mode[MODE_2X_BIT];
    assign loudspeakerModeSelect = cfg_ff.mode[MODE_SPK_BIT];
    assign lowAmplificationSelect = cfg_ff.mode[MODE_LG_BIT];
    assign classAbSelect = cfg_ff.mode[MODE_AB_BIT];
    assign gainCode = cfg_ff.gain;
    assign limiter3CeilingField = cfg_ff.ceil3;
    assign limiter3ReleaseRate = cfg_ff.timing[REL_LSB +: 3];
    assign limiter3AttackRate = cfg_ff.timing[ATK_LSB +: 3];
    assign limiter3InitialAttackRate = cfg_ff.timing[INIT_LSB +: 2];
    assign limiter2CeilingField = cfg_ff.ceil2;

    a_pump_byte_fixed: assert property (@(posedge ref_clk) disable iff (!nrst)
        wrStrobe && wrAddr == ADDR_PUMP |=> cfg_ff.pumpParameterByte == PUMP_RESET)
        else $error("pump parameter byte changed by a write");

    a_gain_lowgain_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        loudspeakerModeSelect && lowAmplificationSelect |-> gainCode <= GAIN_MAX)
        else $error("gain code above range in low-gain mode");

    a_gain_normal_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        loudspeakerModeSelect && !lowAmplificationSelect |-> gainCode >= GAIN_MIN_NORMAL && gainCode <= GAIN_MAX)
        else $error("gain code outside range in loudspeaker mode");

    a_gain_receiver_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        !loudspeakerModeSelect |-> gainCode <= GAIN_MAX_RCV)
        else $error("gain code above range in receiver mode");

    a_gain_fallback: assert property (@(posedge ref_clk) disable iff (!nrst)
        wrStrobe && wrAddr == ADDR_GAIN && !gainOk(wrData[4:0], loudspeakerModeSelect, lowAmplificationSelect)
        |=> gainCode == gainDef($past(loudspeakerModeSelect), $past(lowAmplificationSelect)))
        else $error("reserved gain code not replaced by default");

    a_ceil3_lowgain_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        wrStrobe && wrAddr == ADDR_CEIL3 && loudspeakerModeSelect && lowAmplificationSelect
        |=> limiter3CeilingField == $past(wrData[3:0]))
        else $error("ceiling write lost in low-gain mode");

    a_ceil3_normal_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        loudspeakerModeSelect && !lowAmplificationSelect |-> limiter3CeilingField >= CEIL3_MIN_NORMAL)
        else $error("reserved ceiling code held in loudspeaker mode");

    a_ceil3_receiver_off: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(loudspeakerModeSelect) |-> limiter3CeilingField == CEIL3_OFF ##1 limiter3CeilingField == CEIL3_OFF)
        else $error("ceiling not off after entering receiver mode");

    a_timing_written: assert property (@(posedge ref_clk) disable iff (!nrst)
        wrStrobe && wrAddr == ADDR_TIMING |=> limiter3ReleaseRate == $past(wrData[7:5])
        && limiter3AttackRate == $past(wrData[4:2]) && limiter3InitialAttackRate == $past(wrData[1:0]))
        else $error("timing byte not stored as written");

    a_soft_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
        wrStrobe && wrAddr == ADDR_ID && wrData == ID_RESET_KEY
        |=> gainCode == GAIN_DEF_NORMAL && limiter3CeilingField == CEIL3_DEF_NORMAL
        && cfg_ff.timing == TIMING_RESET && loudspeakerModeSelect && !lowAmplificationSelect)
        else $error("soft reset key did not restore defaults");

endmodule : agl_config_regs

`default_nettype wire

// [core/agl_i2c_target.sv]
`default_nettype none

module agl_i2c_target
    import agl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // serial pins and address straps
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addrPin2,
    input wire logic addrPin1,
    // register side
    output logic wrStrobe,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData,
    output logic [7:0] regPtr,
    input wire logic [7:0] rdData
);

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK} agl_bus_e;

    typedef struct packed {
        agl_bus_e st;
        agl_bus_e after;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic [7:0] ptr;
        logic sclPrev;
        logic sdaPrev;
        logic oe;
        logic drvLevel;
        logic ackSeen;
        logic wrStrobe;
        logic [7:0] wrAddr;
        logic [7:0] wrData;
    } agl_bus_s;

    localparam agl_bus_s BUS_RESET = '{st: ST_IDLE, after: ST_IDLE, sh: 8'h00, cnt: 4'h0, ptr: 8'h00,
        sclPrev: 1'b1, sdaPrev: 1'b1, oe: 1'b0, drvLevel: 1'b0, ackSeen: 1'b0,
        wrStrobe: 1'b0, wrAddr: 8'h00, wrData: 8'h00};

    agl_bus_s bus_ff;
    agl_bus_s nxt_bus;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;

    always_comb begin
        nxt_bus = bus_ff;
        nxt_bus.wrStrobe = 1'b0;
        nxt_bus.sclPrev = sclIn;
        nxt_bus.sdaPrev = sdaIn;
        sclRise = sclIn & ~bus_ff.sclPrev;
        sclFall = ~sclIn & bus_ff.sclPrev;
        startSeen = sclIn & bus_ff.sclPrev & bus_ff.sdaPrev & ~sdaIn;
        stopSeen = sclIn & bus_ff.sclPrev & ~bus_ff.sdaPrev & sdaIn;
        if (startSeen) begin
            nxt_bus.st = ST_ADDR;
            nxt_bus.cnt = 4'h0;
            nxt_bus.oe = 1'b0;
        end else if (stopSeen) begin
            nxt_bus.st = ST_IDLE;
            nxt_bus.oe = 1'b0;
        end else begin
            case (bus_ff.st)
                ST_IDLE: begin
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (sclRise && bus_ff.cnt != BYTE_BITS) begin
                        nxt_bus.sh = {bus_ff.sh[6:0], sdaIn};
                        nxt_bus.cnt = bus_ff.cnt + 4'h1;
                    end else if (sclFall && bus_ff.cnt == BYTE_BITS) begin
                        nxt_bus.cnt = 4'h0;
                        nxt_bus.oe = 1'b1;
                        nxt_bus.st = ST_ACK;
                        case (bus_ff.st)
                            ST_ADDR: begin
                                if (bus_ff.sh[7:1] == {BUS_ADDR_HI, addrPin2, addrPin1}) begin
                                    nxt_bus.after = bus_ff.sh[0] ? ST_RDATA : ST_PTR;
                                end else begin
                                    nxt_bus.oe = 1'b0;
                                    nxt_bus.st = ST_IDLE;
                                end
                            end
                            ST_PTR: begin
                                nxt_bus.ptr = bus_ff.sh;
                                nxt_bus.after = ST_WDATA;
                            end
                            default: begin
                                nxt_bus.wrStrobe = 1'b1;
                                nxt_bus.wrAddr = bus_ff.ptr;
                                nxt_bus.wrData = bus_ff.sh;
                                nxt_bus.ptr = bus_ff.ptr + 8'h01;
                                nxt_bus.after = ST_WDATA;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        nxt_bus.oe = 1'b0;
                        nxt_bus.st = bus_ff.after;
                        if (bus_ff.after == ST_RDATA) begin
                            nxt_bus.sh = rdData;
                            nxt_bus.oe = ~rdData[7];
                            nxt_bus.ptr = bus_ff.ptr + 8'h01;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        nxt_bus.cnt = bus_ff.cnt + 4'h1;
                    end else if (sclFall) begin
                        if (bus_ff.cnt == BYTE_BITS) begin
                            nxt_bus.oe = 1'b0;
                            nxt_bus.cnt = 4'h0;
                            nxt_bus.st = ST_MACK;
                        end else begin
                            nxt_bus.sh = {bus_ff.sh[6:0], 1'b0};
                            nxt_bus.oe = ~bus_ff.sh[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        nxt_bus.ackSeen = ~sdaIn;
                    end else if (sclFall) begin
                        // a not-acknowledge ends the read and frees the line
                        if (bus_ff.ackSeen) begin
                            nxt_bus.st = ST_RDATA;
                            nxt_bus.sh = rdData;
                            nxt_bus.oe = ~rdData[7];
                            nxt_bus.ptr = bus_ff.ptr + 8'h01;
                        end else begin
                            nxt_bus.st = ST_IDLE;
                        end
                    end
                end
                default: begin
                    nxt_bus.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_ff <= BUS_RESET;
        end else begin
            bus_ff <= nxt_bus;
        end
    end

    assign sdaOut = bus_ff.drvLevel;
    assign sdaOe = bus_ff.oe;
    assign wrStrobe = bus_ff.wrStrobe;
    assign wrAddr = bus_ff.wrAddr;
    assign wrData = bus_ff.wrData;
    assign regPtr = bus_ff.ptr;

endmodule : agl_i2c_target

`default_nettype wire

// [core/agl_pkg.sv]
`default_nettype none

package agl_pkg;

    // register offsets
    localparam logic [7:0] ADDR_ID = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h02;
    localparam logic [7:0] ADDR_PUMP = 8'h04;
    localparam logic [7:0] ADDR_GAIN = 8'h05;
    localparam logic [7:0] ADDR_CEIL3 = 8'h06;
    localparam logic [7:0] ADDR_TIMING = 8'h07;
    localparam logic [7:0] ADDR_CEIL2 = 8'h08;

    // identity: value is arbitrary, the reset key is not
    localparam logic [7:0] ID_VALUE = 8'h3c;
    localparam logic [7:0] ID_RESET_KEY = 8'haa;

    // bus target address, upper five bits fixed, two low bits strapped
    localparam logic [4:0] BUS_ADDR_HI = 5'h16;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // mode control field positions and reset
    localparam int MODE_SPK_BIT = 2;
    localparam int MODE_LG_BIT = 1;
    localparam int MODE_AB_BIT = 0;
    localparam int MODE_2X_BIT = 3;
    localparam logic [3:0] MODE_RESET = 4'hc;

    localparam logic [7:0] PUMP_RESET = 8'h05;

    // gain code limits and defaults per mode
    localparam logic [4:0] GAIN_MAX = 5'h11;
    localparam logic [4:0] GAIN_MIN_NORMAL = 5'h08;
    localparam logic [4:0] GAIN_MAX_RCV = 5'h06;
    localparam logic [4:0] GAIN_DEF_LOWG = 5'h00;
    localparam logic [4:0] GAIN_DEF_NORMAL = 5'h10;
    localparam logic [4:0] GAIN_DEF_RCV = 5'h00;

    // third limiter ceiling limits and defaults per mode
    localparam logic [3:0] CEIL3_OFF = 4'hf;
    localparam logic [3:0] CEIL3_MIN_NORMAL = 4'h4;
    localparam logic [3:0] CEIL3_DEF_LOWG = 4'h0;
    localparam logic [3:0] CEIL3_DEF_NORMAL = 4'h7;
    localparam logic [3:0] CEIL3_DEF_RCV = 4'hf;

    // second limiter ceiling
    localparam logic [3:0] CEIL2_MAX_SPK = 4'h9;
    localparam logic [3:0] CEIL2_OFF_RCV = 4'h9;
    localparam logic [3:0] CEIL2_DEF_SPK = 4'h6;

    // third limiter timing byte: release 7:5, attack 4:2, first attack 1:0
    localparam int REL_LSB = 5;
    localparam int ATK_LSB = 2;
    localparam int INIT_LSB = 0;
    localparam logic [7:0] TIMING_RESET = 8'h4e;

endpackage : agl_pkg

`default_nettype wire

// [test/agl_config_regs_tb.sv]
`default_nettype none

module agl_config_regs_tb
    import agl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic adr2, adr1, scl, hostLow, sdaOut, sdaOe, cpd, spk, lg, ab;
    wire logic sdaLine;
    logic [4:0] gc, mGain;
    logic [3:0] c3, mMode, mCeil, c2, mCeil2;
    logic [2:0] rel, atk;
    logic [1:0] ini;
    logic [7:0] mTime;
    logic [6:0] dev;
    logic [7:0] expQ[$];
    logic [4:0] gList[6] = '{5'h06, 5'h07, 5'h08, 5'h11, 5'h12, 5'h1f};
    logic [15:0] modeSeq[8] = '{16'h0206, 16'h0502, 16'h0600, 16'h0200, 16'h0206, 16'h0511, 16'h0603, 16'h0204};
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int seedVal;

    // open drain wire with pull-up
    assign sdaLine = ~(sdaOe | hostLow);

    initial forever #20 ref_clk = ~ref_clk;

    agl_config_regs agl_config_regs_inst (
        .ref_clk(ref_clk), .nrst(nrst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrPin2(adr2), .addrPin1(adr1), .chargePumpDouble(cpd), .loudspeakerModeSelect(spk),
        .lowAmplificationSelect(lg), .classAbSelect(ab), .gainCode(gc), .limiter3CeilingField(c3),
        .limiter3ReleaseRate(rel), .limiter3AttackRate(atk), .limiter3InitialAttackRate(ini),
        .limiter2CeilingField(c2)
    );

    agl_host_model agl_host_model_inst (.ref_clk(ref_clk), .sdaLine(sdaLine), .sclOut(scl), .sdaLow(hostLow));

    function automatic logic [4:0] fix_gain(input logic [3:0] m, input logic [4:0] c);
        if (m[2] && m[1]) return (c <= 5'h11) ? c : 5'h00;
        if (m[2]) return (c >= 5'h08 && c <= 5'h11) ? c : 5'h10;
        return (c <= 5'h06) ? c : 5'h00;
    endfunction : fix_gain

    function automatic logic [3:0] fix_ceil(input logic [3:0] m, input logic [3:0] c);
        if (m[2] && m[1]) return c;
        if (m[2]) return (c >= 4'h4) ? c : 4'h7;
        return 4'hf;
    endfunction : fix_ceil

    task automatic set_defaults();
        mMode = 4'hc;
        mGain = 5'h10;
        mCeil = 4'h7;
        mTime = 8'h4e;
        mCeil2 = 4'h6;
    endtask : set_defaults

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        agl_host_model_inst.wr(dev, r, d);
        chk({7'h0, agl_host_model_inst.gotAck}, 8'h01);
        case (r)
            ADDR_MODE: mMode = d[3:0];
            ADDR_GAIN: mGain = d[4:0];
            ADDR_CEIL3: mCeil = d[3:0];
            ADDR_TIMING: mTime = d;
            ADDR_CEIL2: mCeil2 = d[3:0];
            ADDR_ID: if (d == ID_RESET_KEY) set_defaults();
            default: ;
        endcase
        mGain = fix_gain(mMode, mGain);
        mCeil = fix_ceil(mMode, mCeil);
        // second ceiling: codes up to 9 in loudspeaker mode, only 9 in receiver mode
        mCeil2 = mMode[2] ? ((mCeil2 <= 4'h9) ? mCeil2 : 4'h6) : 4'h9;
    endtask : wr

    task automatic rdx(input logic [7:0] r, input logic [7:0] e);
        expQ.push_back(e);
        agl_host_model_inst.rd(dev, r, 1);
    endtask : rdx

    task automatic rd2(input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1);
        expQ.push_back(e0);
        expQ.push_back(e1);
        agl_host_model_inst.rd(dev, r, 2);
    endtask : rd2

    task automatic check_all();
        rdx(ADDR_MODE, {4'h0, mMode});
        rdx(ADDR_PUMP, 8'h05);
        rdx(ADDR_GAIN, {3'h0, mGain});
        rdx(ADDR_CEIL3, {4'h0, mCeil});
        rdx(ADDR_TIMING, mTime);
        rdx(ADDR_CEIL2, {4'h0, mCeil2});
        chk({3'h0, sdaOut, c2}, {4'h0, mCeil2});
        chk({rel, atk, ini}, mTime);
        chk({gc, c3[3:1]}, {mGain, mCeil[3:1]});
        chk({3'h0, c3[0], cpd, spk, lg, ab}, {3'h0, mCeil[0], mMode});
    endtask : check_all

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // results are judged in arrival order against the notes left by the driver
    initial forever begin
        @(agl_host_model_inst.readDone);
        chk(agl_host_model_inst.rxByte, expQ.pop_front());
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 90000) begin
            n_fail++;
            $display("run cut short after %0d cycles", cycles);
            give_verdict();
        end
    end

    initial begin
        seedVal = $urandom(32'h6240);
        adr2 = 1'($urandom);
        adr1 = 1'($urandom);
        dev = {BUS_ADDR_HI, adr2, adr1};
        set_defaults();
        repeat (2) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (2) @(negedge ref_clk);
        check_all();
        rdx(ADDR_ID, ID_VALUE);
        rdx(8'h0b, 8'h00);
        $display("reset values done");
        for (int m = 0; m < 8; m++) begin
            agl_host_model_inst.hold = 2 + m % 3;
            wr(ADDR_MODE, {4'h0, 1'($urandom), m[2:0]});
            for (int k = 0; k < 2; k++) begin
                wr(ADDR_GAIN, {3'($urandom), gList[$urandom % 6]});
                wr(ADDR_CEIL3, 8'($urandom));
                rdx(ADDR_GAIN, {3'h0, mGain});
                rdx(ADDR_CEIL3, {4'h0, mCeil});
            end
            wr(ADDR_TIMING, 8'($urandom));
            wr(ADDR_CEIL2, 8'($urandom));
            rd2(ADDR_TIMING, mTime, {4'h0, mCeil2});
            wr(ADDR_PUMP, 8'($urandom));
            check_all();
        end
        $display("mode sweep done");
        for (int i = 0; i < 8; i++) begin
            wr(modeSeq[i][15:8], modeSeq[i][7:0]);
            if (i % 4 == 3) check_all();
        end
        $display("mode change done");
        agl_host_model_inst.wr({BUS_ADDR_HI, ~adr2, adr1}, ADDR_TIMING, ~mTime);
        chk({7'h0, agl_host_model_inst.gotAck}, 8'h00);
        check_all();
        $display("foreign address done");
        wr(ADDR_ID, 8'h55);
        check_all();
        wr(ADDR_ID, ID_RESET_KEY);
        check_all();
        $display("soft reset done");
        repeat (4) @(negedge ref_clk);
        chk(8'(expQ.size()), 8'h00);
        give_verdict();
    end

endmodule : agl_config_regs_tb

`default_nettype wire

// [test/agl_host_model.sv]
`default_nettype none

module agl_host_model (
    // clock and resolved data line
    input wire logic ref_clk,
    input wire logic sdaLine,
    // driven bus pins
    output logic sclOut,
    output logic sdaLow
);
    timeunit 1ns;
    timeprecision 1ns;

    int hold = 2;
    logic gotAck = 1'b0;
    logic [7:0] rxByte = 8'h00;
    event readDone;

    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick

    // start, also used as repeated start
    task automatic start_cond();
        sdaLow = 1'b0;
        tick(hold);
        sclOut = 1'b1;
        tick(hold);
        sdaLow = 1'b1;
        tick(hold);
        sclOut = 1'b0;
        tick(1);
    endtask : start_cond

    task automatic stop_cond();
        sdaLow = 1'b1;
        tick(hold);
        sclOut = 1'b1;
        tick(hold);
        sdaLow = 1'b0;
        tick(hold);
    endtask : stop_cond

    // data moves one clock after scl falls, so it never looks like a start or stop
    task automatic clk_bit(input logic b, output logic s);
        sdaLow = ~b;
        tick(hold);
        sclOut = 1'b1;
        tick(hold);
        s = sdaLine;
        sclOut = 1'b0;
        tick(1);
    endtask : clk_bit

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask : put_byte

    task automatic wr(input logic [6:0] dev, input logic [7:0] r, input logic [7:0] d);
        logic a0, a1, a2;
        start_cond();
        put_byte({dev, 1'b0}, a0);
        put_byte(r, a1);
        put_byte(d, a2);
        stop_cond();
        gotAck = a0 & a1 & a2;
    endtask : wr

    // reads n bytes in a row, every byte acked but the last, which gets a nack
    task automatic rd(input logic [6:0] dev, input logic [7:0] r, input int n);
        logic a0, a1, a2, s;
        start_cond();
        put_byte({dev, 1'b0}, a0);
        put_byte(r, a1);
        start_cond();
        put_byte({dev, 1'b1}, a2);
        for (int k = n; k > 0; k--) begin
            for (int i = 7; i >= 0; i--) clk_bit(1'b1, rxByte[i]);
            clk_bit(k == 1, s);
            -> readDone;
        end
        stop_cond();
        gotAck = a0 & a1 & a2;
    endtask : rd

endmodule : agl_host_model

`default_nettype wire
